// *** src/atd_params.svh ***
// Named constants for the accumulator transfer decoder: opcodes, register
// offsets, field positions and reset values.
// Assumes it is included by bare name from every file that needs a figure.
`ifndef ATD_PARAMS_SVH
`define ATD_PARAMS_SVH

// Ten-bit instruction codes handled by this block.
`define ATD_CODE_LOAD_TC2 10'h20F
`define ATD_CODE_LOAD_TC3 10'h210
`define ATD_CODE_LOAD_TC4 10'h211
`define ATD_CODE_LOAD_Y 10'h00C
`define ATD_CODE_WD_RESTART 10'h2A0
`define ATD_CODE_WD_DISABLE 10'h29C

// Register byte offsets inside the 4 KB slave window.
`define ATD_ADDR_TC2 12'h000
`define ATD_ADDR_TC3 12'h004
`define ATD_ADDR_TC4 12'h008
`define ATD_ADDR_Y 12'h00C
`define ATD_ADDR_STATUS 12'h010
`define ATD_ADDR_CTRL 12'h014

// Status and control field positions.
`define ATD_ST_WATCHDOG_FLAG_FIRST_BIT 0
`define ATD_ST_STOP_BIT 1
`define ATD_ST_DISPEND_BIT 2
`define ATD_CTRL_EN_BIT 0

// Reset values.
`define ATD_NIBBLE_RESET 4'h0
`define ATD_CTRL_RESET 4'h1

// Bus encodings.
`define ATD_HSIZE_WORD 3'h2
`define ATD_HRESP_OKAY 1'h0
`define ATD_WORD_ZERO 32'h00000000

`endif

// *** src/atd_pkg.sv ***
// Types shared by the accumulator transfer decoder and its opcode decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package atd_pkg;

   // Decoded operation for the instruction executing this cycle.
   typedef enum logic [2:0] {
      op_none,
      load_timer_ctrl_two_from_acc,
      load_timer_ctrl_three_from_acc,
      load_timer_ctrl_four_from_acc,
      load_y_pointer_from_acc,
      watchdog_restart_op,
      watchdog_disable_op,
      op_other
   } atd_op_t;

   // Register selected by a bus address.
   typedef enum logic [2:0] {
      reg_tc2,
      reg_tc3,
      reg_tc4,
      reg_y,
      reg_status,
      reg_ctrl,
      reg_none
   } atd_reg_t;

endpackage

// *** src/atd_dec_if.sv ***
// Carrier between the transfer block and its opcode decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface atd_dec_if;
   logic instr_valid;
   logic [9:0] instr_code;
   logic enable;
   atd_pkg::atd_op_t op;

   // The decoder looks at the fetched word and names the operation.
   modport dec
   (
      input instr_valid,
      input instr_code,
      input enable,
      output op
   );

   // The executing logic supplies the word and uses the result.
   modport exec
   (
      output instr_valid,
      output instr_code,
      output enable,
      input op
   );
endinterface

`default_nettype wire

// *** src/atd_decode.sv ***
// Opcode decoder: turns a fetched ten-bit word into an operation.
// Assumes the word and its valid strobe are stable for the whole cycle.
`include "atd_params.svh"
`timescale 1ns/100ps
`default_nettype none

module atd_decode
(
   // Decoder side of the carrier.
   atd_dec_if.dec dif
);
   import atd_pkg::*;

   // Pure decode; an unknown word still counts as an executed instruction
   // so that a pending disable is dropped by anything in between.
   always_comb
   begin
      if (!dif.instr_valid || !dif.enable)
      begin
         dif.op = op_none;
      end
      else
      begin
         case (dif.instr_code)
            `ATD_CODE_LOAD_TC2: dif.op = load_timer_ctrl_two_from_acc;
            `ATD_CODE_LOAD_TC3: dif.op = load_timer_ctrl_three_from_acc;
            `ATD_CODE_LOAD_TC4: dif.op = load_timer_ctrl_four_from_acc;
            `ATD_CODE_LOAD_Y: dif.op = load_y_pointer_from_acc;
            `ATD_CODE_WD_RESTART: dif.op = watchdog_restart_op;
            `ATD_CODE_WD_DISABLE: dif.op = watchdog_disable_op;
            default: dif.op = op_other;
         endcase
      end
   end
endmodule // atd_decode

`default_nettype wire

// *** src/atd_core.sv ***
// Accumulator transfer and watchdog restart execution for a 4-bit core,
// with an AHB-Lite slave that exposes the destination registers.
// Assumes the core presents one executing instruction per valid cycle and
// never asserts valid for an instruction that it skips.
`include "atd_params.svh"
`timescale 1ns/100ps
`default_nettype none

module atd_core
(
   // Clock and synchronous reset.
   input wire logic clk,
   input wire logic reset,
   // Instruction stream from the core.
   input wire logic instr_valid,
   input wire logic [9:0] instr_code,
   input wire logic [3:0] acc,
   // Watchdog counter interface.
   input wire logic watchdog_flag_first_set,
   output logic watchdog_restart,
   output logic watchdog_stop,
   output logic watchdog_flag_first,
   // Sequencer interface.
   output logic skip_next,
   // Destination registers.
   output logic [3:0] timer_ctrl_two,
   output logic [3:0] timer_ctrl_three,
   output logic [3:0] timer_ctrl_four,
   output logic [3:0] y_pointer,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import atd_pkg::*;

   // Map a byte address onto a register; used by both read and write paths.
   function automatic atd_reg_t reg_of(input logic [31:0] addr);
      atd_reg_t r;
      r = reg_none;
      case (addr[11:0])
         `ATD_ADDR_TC2: r = reg_tc2;
         `ATD_ADDR_TC3: r = reg_tc3;
         `ATD_ADDR_TC4: r = reg_tc4;
         `ATD_ADDR_Y: r = reg_y;
         `ATD_ADDR_STATUS: r = reg_status;
         `ATD_ADDR_CTRL: r = reg_ctrl;
         default: r = reg_none;
      endcase
      return r;
   endfunction

   // Operation that loads a given timer control slot.
   function automatic atd_op_t timer_op(input int idx);
      atd_op_t o;
      case (idx)
         0: o = load_timer_ctrl_two_from_acc;
         1: o = load_timer_ctrl_three_from_acc;
         2: o = load_timer_ctrl_four_from_acc;
         default: o = op_none;
      endcase
      return o;
   endfunction

   // Decoder instance through the carrier.
   atd_dec_if dif ();
   atd_op_t op;
   logic [3:0] ctrl;

   // Drive the carrier from the instruction port and the enable bit.
   always_comb
   begin
      dif.instr_valid = instr_valid;
      dif.instr_code = instr_code;
      dif.enable = ctrl[`ATD_CTRL_EN_BIT];
      op = dif.op;
   end

   atd_decode u_decode
   (
      .dif(dif)
   );

   // Bus state.
   logic wr_pend;
   logic next_wr_pend;
   atd_reg_t wr_reg;
   atd_reg_t next_wr_reg;
   logic [31:0] next_hrdata;
   logic [3:0] next_ctrl;
   logic bus_take;

   // Execution state.
   logic [3:0] timer_ctrl [0:2];
   logic [3:0] next_timer_ctrl [0:2];
   logic [3:0] next_y_pointer;
   logic next_watchdog_flag_first;
   logic disable_pending;
   logic next_disable_pending;
   logic next_watchdog_stop;
   logic restart_exec;

   // A transfer is taken in its address phase when selected and the bus
   // is ready; only NONSEQ or SEQ count. IDLE and BUSY cycles are ignored,
   // so a master that parks on this slave between transfers does no harm.
   // The write data arrives one cycle later, so only the target register
   // is remembered here and the value is taken from hwdata in the data
   // phase.
   assign bus_take = hsel && hready && htrans[1];

   // The slave never inserts wait states and always answers OKAY. Every
   // register is a plain flip-flop, so nothing could make a transfer wait
   // or fail; unmapped offsets simply read as zero.
   assign hreadyout = 1'b1;
   assign hresp = `ATD_HRESP_OKAY;

   // Capture the write address phase and prepare read data for the data
   // phase. Read data is sampled in the address phase, so a read placed
   // directly behind a write to the same register returns the old value.
   always_comb
   begin
      next_wr_pend = bus_take && hwrite && (hsize == `ATD_HSIZE_WORD);
      next_wr_reg = bus_take ? reg_of(haddr) : reg_none;
      next_hrdata = `ATD_WORD_ZERO;
      if (bus_take && !hwrite)
      begin
         case (reg_of(haddr))
            reg_tc2: next_hrdata[3:0] = timer_ctrl[0];
            reg_tc3: next_hrdata[3:0] = timer_ctrl[1];
            reg_tc4: next_hrdata[3:0] = timer_ctrl[2];
            reg_y: next_hrdata[3:0] = y_pointer;
            reg_status:
            begin
               next_hrdata[`ATD_ST_WATCHDOG_FLAG_FIRST_BIT] = watchdog_flag_first;
               next_hrdata[`ATD_ST_STOP_BIT] = watchdog_stop;
               next_hrdata[`ATD_ST_DISPEND_BIT] = disable_pending;
            end
            reg_ctrl: next_hrdata[3:0] = ctrl;
            default: next_hrdata = `ATD_WORD_ZERO;
         endcase
      end
   end

   // Control register: only software writes it. Clearing the enable bit
   // freezes every destination and the pending disable until it is set
   // again; bus writes to the destinations still land meanwhile.
   always_comb
   begin
      next_ctrl = ctrl;
      if (wr_pend && wr_reg == reg_ctrl)
      begin
         next_ctrl = hwdata[3:0];
      end
   end

   // Bus registers.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wr_pend <= 1'b0;
         wr_reg <= reg_none;
         hrdata <= `ATD_WORD_ZERO;
         ctrl <= `ATD_CTRL_RESET;
      end
      else
      begin
         wr_pend <= next_wr_pend;
         wr_reg <= next_wr_reg;
         hrdata <= next_hrdata;
         ctrl <= next_ctrl;
      end
   end

   // One slot per timer control register. An executing load wins over a
   // bus write in the same cycle, since the program owns the timer setup.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_timer
         always_comb
         begin
            next_timer_ctrl[gi] = timer_ctrl[gi];
            if (op == timer_op(gi))
            begin
               next_timer_ctrl[gi] = acc;
            end
            else if (wr_pend && wr_reg == atd_reg_t'(3'(gi)))
            begin
               next_timer_ctrl[gi] = hwdata[3:0];
            end
         end

         // Written at the end of the executing cycle.
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               timer_ctrl[gi] <= `ATD_NIBBLE_RESET;
            end
            else
            begin
               timer_ctrl[gi] <= next_timer_ctrl[gi];
            end
         end
      end
   endgenerate

   assign timer_ctrl_two = timer_ctrl[0];
   assign timer_ctrl_three = timer_ctrl[1];
   assign timer_ctrl_four = timer_ctrl[2];

   // Y pointer: accumulator copy, or a software write when no load runs.
   // The accumulator is only read here, never written back.
   always_comb
   begin
      next_y_pointer = y_pointer;
      if (op == load_y_pointer_from_acc)
      begin
         next_y_pointer = acc;
      end
      else if (wr_pend && wr_reg == reg_y)
      begin
         next_y_pointer = hwdata[3:0];
      end
   end

   // Watchdog restart handling. The skip is judged on the flag value
   // before the clear, so it is a same-cycle combinational answer.
   assign restart_exec = (op == watchdog_restart_op);
   assign skip_next = restart_exec && watchdog_flag_first;
   // A restart that follows a disable stops the timer instead; idle cycles
   // in between do not break the pair, only another executed instruction does.
   assign watchdog_restart = restart_exec && !disable_pending;

   always_comb
   begin
      // Flag: a set from the counter wins over the clear by the opcode,
      // so a timeout landing in the restart cycle is never lost.
      next_watchdog_flag_first = watchdog_flag_first;
      if (watchdog_flag_first_set)
      begin
         next_watchdog_flag_first = 1'b1;
      end
      else if (restart_exec)
      begin
         next_watchdog_flag_first = 1'b0;
      end
      // Disable is pending only until the next executed instruction.
      next_disable_pending = disable_pending;
      if (op != op_none)
      begin
         next_disable_pending = (op == watchdog_disable_op);
      end
      // Stop is sticky; only reset brings the watchdog back.
      next_watchdog_stop = watchdog_stop;
      if (restart_exec && disable_pending)
      begin
         next_watchdog_stop = 1'b1;
      end
   end

   // Execution registers. The flag, the pending disable and the stop bit
   // all update on the edge that ends the executing instruction, so the
   // next instruction already sees the new state.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         y_pointer <= `ATD_NIBBLE_RESET;
         watchdog_flag_first <= 1'b0;
         disable_pending <= 1'b0;
         watchdog_stop <= 1'b0;
      end
      else
      begin
         y_pointer <= next_y_pointer;
         watchdog_flag_first <= next_watchdog_flag_first;
         disable_pending <= next_disable_pending;
         watchdog_stop <= next_watchdog_stop;
      end
   end

endmodule // atd_core

`default_nettype wire

// *** tb/atd_core_properties.sv ***
// Checker for the transfer block's instruction side.
// Assumes decode stays enabled and no bus write races a load.
`include "atd_params.svh"
`timescale 1ns/100ps
`default_nettype none

module atd_core_properties
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Instruction side.
   input wire logic instr_valid,
   input wire logic [9:0] instr_code,
   input wire logic [3:0] acc,
   input wire logic watchdog_flag_first_set,
   // Results.
   input wire logic watchdog_restart,
   input wire logic watchdog_stop,
   input wire logic watchdog_flag_first,
   input wire logic skip_next,
   input wire logic [3:0] timer_ctrl_two,
   input wire logic [3:0] timer_ctrl_three,
   input wire logic [3:0] timer_ctrl_four,
   input wire logic [3:0] y_pointer
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // Restart presented straight after disable.
   sequence s_dis_rst;
      instr_valid && instr_code == `ATD_CODE_WD_DISABLE
      ##1 instr_valid && instr_code == `ATD_CODE_WD_RESTART;
   endsequence

   // Each load shows the accumulator one edge later.
   a_load_two:
   assert property (instr_valid && instr_code == `ATD_CODE_LOAD_TC2
      |=> timer_ctrl_two == $past(acc)) else $error("two load wrong");
   a_load_three:
   assert property (instr_valid && instr_code == `ATD_CODE_LOAD_TC3
      |=> timer_ctrl_three == $past(acc)) else $error("three load wrong");
   a_load_four:
   assert property (instr_valid && instr_code == `ATD_CODE_LOAD_TC4
      |=> timer_ctrl_four == $past(acc)) else $error("four load wrong");
   a_load_y:
   assert property (instr_valid && instr_code == `ATD_CODE_LOAD_Y
      |=> y_pointer == $past(acc)) else $error("y load wrong");
   // The skip follows the flag as it stood before the restart.
   a_restart_skip:
   assert property (instr_valid && instr_code == `ATD_CODE_WD_RESTART
      |-> skip_next == watchdog_flag_first) else $error("skip wrong");
   a_flag_clear:
   assert property (instr_valid && instr_code == `ATD_CODE_WD_RESTART && !watchdog_flag_first_set
      |=> !watchdog_flag_first) else $error("flag not cleared");
   a_only_skip:
   assert property (skip_next |-> instr_valid && instr_code == `ATD_CODE_WD_RESTART)
      else $error("stray skip");
   a_dis_stop:
   assert property (s_dis_rst |-> !watchdog_restart ##1 watchdog_stop)
      else $error("watchdog not stopped");
   a_y_hold:
   assert property (instr_valid && instr_code == `ATD_CODE_LOAD_TC2
      |=> $stable(y_pointer)) else $error("y changed");
endmodule // atd_core_properties

bind atd_core atd_core_properties atd_core_properties_i
(
   .clk, .reset, .instr_valid, .instr_code, .acc, .watchdog_flag_first_set,
   .watchdog_restart, .watchdog_stop, .watchdog_flag_first, .skip_next,
   .timer_ctrl_two, .timer_ctrl_three, .timer_ctrl_four, .y_pointer
);

`default_nettype wire

// *** tb/atd_core_tb.sv ***
// Bench for the transfer block: loads, watchdog restart and bus access.
// Assumes the checker is bound in and the slave keeps hready high.
`include "atd_params.svh"
`timescale 1ns/100ps
`default_nettype none

module atd_core_tb;
   logic clk, reset, instr_valid, watchdog_flag_first_set, hsel, hwrite, sk, rs;
   logic hreadyout, hresp, watchdog_restart, watchdog_stop, watchdog_flag_first, skip_next;
   logic [9:0] instr_code;
   logic [3:0] acc, tc2, tc3, tc4, yp;
   logic [31:0] haddr, hwdata, hrdata, rd_q, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] m [4];
   logic [9:0] codes [5];
   int n_fail, checks;

   atd_core atd_core_i
   (
      .clk, .reset, .instr_valid, .instr_code, .acc, .watchdog_flag_first_set,
      .watchdog_restart, .watchdog_stop, .watchdog_flag_first, .skip_next,
      .timer_ctrl_two(tc2), .timer_ctrl_three(tc3), .timer_ctrl_four(tc4),
      .y_pointer(yp), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp
   );

   // Free-running clock.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Latch read data at the edge so the taker never races the register.
   always @(posedge clk) rd_q <= hrdata;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Every destination against the model.
   task automatic cmp();
      chk(tc2, m[0]);
      chk(tc3, m[1]);
      chk(tc4, m[2]);
      chk(yp, m[3]);
   endtask

   // Present one instruction; the previous one's results land first.
   task automatic ex(input logic [9:0] c, input logic [3:0] a);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_code <= c;
      acc <= a;
      #1;
      cmp();
      sk = skip_next;
      rs = watchdog_restart;
      for (int k = 0; k < 4; k++)
         if (c === codes[k]) m[k] = a;
   endtask

   task automatic idle();
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      cmp();
   endtask

   // Bounded wait for hready at an edge.
   task automatic wt();
      int i;
      i = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1)
      begin
         @(posedge clk);
         i++;
         if (i > 20)
         begin
            n_fail++;
            final_report();
         end
      end
   endtask

   // One single word transfer; read data ends up in r.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      #1;
      r = rd_q;
   endtask

   initial
   begin
      reset = 1'b1;
      instr_valid = 1'b0;
      instr_code = 10'h000;
      acc = 4'h0;
      watchdog_flag_first_set = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      n_fail = 0;
      checks = 0;
      m = '{4'h0, 4'h0, 4'h0, 4'h0};
      codes = '{`ATD_CODE_LOAD_TC2, `ATD_CODE_LOAD_TC3, `ATD_CODE_LOAD_TC4,
         `ATD_CODE_LOAD_Y, 10'h155};
      void'($urandom(32'hAC9F));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      // Back-to-back random loads with an unrelated opcode mixed in.
      repeat (60) ex(codes[$urandom_range(4)], 4'($urandom));
      idle();
      // A set flag makes restart skip; the cleared flag does not.
      @(posedge clk);
      watchdog_flag_first_set <= 1'b1;
      @(posedge clk);
      watchdog_flag_first_set <= 1'b0;
      ex(`ATD_CODE_WD_RESTART, 4'h0);
      chk(sk, 1'b1);
      chk(rs, 1'b1);
      chk(watchdog_flag_first, 1'b1);
      ex(`ATD_CODE_WD_RESTART, 4'h0);
      chk(sk, 1'b0);
      chk(watchdog_flag_first, 1'b0);
      chk(watchdog_stop, 1'b0);
      ex(`ATD_CODE_WD_DISABLE, 4'h0);
      ex(`ATD_CODE_WD_RESTART, 4'h0);
      chk(rs, 1'b0);
      idle();
      chk(watchdog_stop, 1'b1);
      // Bus write and reads, then a load overrides the bus value.
      xfer(1'b1, 32'h4, 32'h0000000A);
      m[1] = 4'hA;
      cmp();
      xfer(1'b0, 32'h4, 32'h0);
      chk(r, 32'hA);
      xfer(1'b0, 32'h20, 32'h0);
      chk(r, 32'h0);
      xfer(1'b0, 32'h10, 32'h0);
      chk(r[1], 1'b1);
      chk(r, 32'h00000002);
      chk(hresp, `ATD_HRESP_OKAY);
      // Decode enable comes out of reset set.
      xfer(1'b0, 32'h14, 32'h0);
      chk(r, 32'h00000001);
      ex(`ATD_CODE_LOAD_TC3, 4'h5);
      idle();
      final_report();
   end
endmodule // atd_core_tb

`default_nettype wire
